//--- inc/amx_regs.vh
// Purpose: constants of the authentication message framer
// Assumes: one clock, byte-wide message streams, most significant octet first
// Notes: element lengths count the identifier and length octets
`ifndef AMX_REGS_VH
`define AMX_REGS_VH

// message type codes, most significant bit always zero
`define AMX_MT_REQ 8'h20
`define AMX_MT_REPLY 8'h41
`define AMX_MT_MSB 7

// element identifier codes
`define AMX_EI_RAND 8'h0C
`define AMX_EI_RES 8'h0D
`define AMX_EI_SEED 8'h0E
`define AMX_EI_KTYPE 8'h0A

// whole element lengths in octets
`define AMX_LEN_RAND 8'h0A
`define AMX_LEN_RES 8'h06
`define AMX_LEN_SEED 8'h0A
`define AMX_LEN_KTYPE 8'h05
// identifier octet plus length octet
`define AMX_LEN_OVH 8'h02

// transmit frame sizes in octets
`define AMX_TX_BYTES 5'h16
`define AMX_TX_REQ_BYTES 5'h10
`define AMX_TX_REQ_RES_BYTES 5'h16
`define AMX_TX_REPLY_BYTES 5'h07

`endif

//--- verilog/amx_ie_parser.v
// Purpose: splits a received message into type, element headers and content
// Assumes: rx_last_in marks the final octet of every message
// Notes: element content length comes from the length octet
`timescale 1ns/10ps
`include "amx_regs.vh"

module amx_ie_parser
(
  // clock and reset
  input wire mclk_in,
  input wire resetn_in,
  // received octet stream
  input wire rx_valid_in,
  input wire [7:0] rx_data_in,
  input wire rx_last_in,
  // decoded octet qualifiers
  output wire type_vld_out,
  output wire id_vld_out,
  output wire len_vld_out,
  output wire body_vld_out,
  output wire elem_last_out,
  output wire [7:0] elem_id_out,
  output wire msg_end_out,
  output wire msg_end_ok_out
);

  // parser states
  localparam ST_TYPE = 2'b00;
  localparam ST_ID = 2'b01;
  localparam ST_LEN = 2'b10;
  localparam ST_BODY = 2'b11;

  reg [1:0] state_r; // current octet role
  reg [1:0] state_nxt;
  reg [7:0] id_r; // identifier of the element being read
  reg [7:0] id_nxt;
  reg [7:0] left_r; // content octets still to come
  reg [7:0] left_nxt;

  // qualifiers of the octet on the input this cycle
  assign type_vld_out = rx_valid_in && (state_r == ST_TYPE);
  assign id_vld_out = rx_valid_in && (state_r == ST_ID);
  assign len_vld_out = rx_valid_in && (state_r == ST_LEN);
  assign body_vld_out = rx_valid_in && (state_r == ST_BODY);
  assign elem_last_out = body_vld_out && (left_r == 8'h01);
  assign elem_id_out = id_r;
  assign msg_end_out = rx_valid_in && rx_last_in;
  // a message ends cleanly only on an element boundary
  assign msg_end_ok_out = msg_end_out &&
    (type_vld_out || elem_last_out || (len_vld_out && rx_data_in == 8'h00));

  ////////////////////////////////////////////////////////////////////////////
  // next state of the octet walker
  always @*
  begin
    state_nxt = state_r;
    id_nxt = id_r;
    left_nxt = left_r;
    if (rx_valid_in)
    begin
      case (state_r)
        ST_TYPE:
          state_nxt = ST_ID;
        ST_ID:
        begin
          id_nxt = rx_data_in;
          state_nxt = ST_LEN;
        end
        ST_LEN:
        begin
          left_nxt = rx_data_in;
          // empty element goes straight to the next identifier
          state_nxt = (rx_data_in == 8'h00) ? ST_ID : ST_BODY;
        end
        ST_BODY:
        begin
          left_nxt = left_r - 8'h01;
          if (left_r == 8'h01)
            state_nxt = ST_ID;
        end
        default:
          state_nxt = ST_TYPE;
      endcase
      // every message restarts at its type octet
      if (rx_last_in)
        state_nxt = ST_TYPE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      state_r <= ST_TYPE;
      id_r <= 8'h00;
      left_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      id_r <= id_nxt;
      left_r <= left_nxt;
    end
  end

endmodule // amx_ie_parser

//--- verilog/amx_auth_pp.v
// Purpose: portable side framer and checker of the authentication exchange
// Assumes: response values are computed outside and handed in
// Notes: one octet per accepted beat on both streams
`timescale 1ns/10ps
`include "amx_regs.vh"

module amx_auth_pp
(
  // clock and reset
  input wire mclk_in,
  input wire resetn_in,
  // received messages
  input wire rx_valid_in,
  input wire [7:0] rx_data_in,
  input wire rx_last_in,
  // transmitted messages
  output wire tx_valid_out,
  output wire [7:0] tx_data_out,
  output wire tx_last_out,
  input wire tx_ready_in,
  // portable originated challenge
  input wire start_auth_in,
  input wire [63:0] rand_p_in,
  input wire [23:0] key_type_in,
  input wire key_alloc_in,
  input wire [31:0] alloc_response_in,
  // fixed originated challenge
  output reg challenge_out,
  output reg [63:0] rand_f_out,
  output reg [63:0] seed_element_out,
  output reg [23:0] key_type_out,
  input wire resp_valid_in,
  input wire [31:0] portable_response_in,
  // fixed part answer and check
  output reg reply_out,
  output reg [31:0] fixed_response_out,
  input wire xres_valid_in,
  input wire [31:0] expected_fixed_response_in,
  output reg auth_pass_out,
  output reg drop_call_out,
  // status
  output reg msg_error_out,
  output wire busy_out
);

  // control states
  localparam ST_IDLE = 3'b000;
  localparam ST_TX = 3'b001;
  localparam ST_WREPLY = 3'b010;
  localparam ST_WXRES = 3'b011;
  localparam ST_WRES = 3'b100;

  // expected content length of a known element, zero when unknown
  function [7:0] amx_exp_len;
    input [7:0] id;
    begin
      case (id)
        `AMX_EI_RAND: amx_exp_len = `AMX_LEN_RAND - `AMX_LEN_OVH;
        `AMX_EI_RES: amx_exp_len = `AMX_LEN_RES - `AMX_LEN_OVH;
        `AMX_EI_SEED: amx_exp_len = `AMX_LEN_SEED - `AMX_LEN_OVH;
        `AMX_EI_KTYPE: amx_exp_len = `AMX_LEN_KTYPE - `AMX_LEN_OVH;
        default: amx_exp_len = 8'h00;
      endcase
    end
  endfunction

  wire type_vld; // type octet on input
  wire id_vld; // identifier octet on input
  wire len_vld; // length octet on input
  wire body_vld; // content octet on input
  wire elem_last; // last content octet of an element
  wire [7:0] elem_id; // identifier of the current element
  wire msg_end; // final octet of a message
  wire msg_end_ok; // final octet on an element boundary

  reg [2:0] state_r; // control state
  reg tx_is_req_r; // frame in flight is a request
  reg [175:0] frame_r; // transmit frame, head octet on top
  reg [4:0] tx_cnt_r; // octets left to send
  reg [7:0] mtype_r; // received message type
  reg bad_r; // received message already faulty
  reg [3:0] seen_r; // elements seen: key type, seed, response, challenge
  reg [63:0] rand_acc_r; // received challenge content
  reg [63:0] seed_acc_r; // received seed content
  reg [31:0] res_acc_r; // received response content
  reg [23:0] ktype_acc_r; // received key type content

  wire tx_fire; // octet handed to the link
  wire [7:0] klen; // expected length of the element being opened

  assign tx_fire = tx_valid_out && tx_ready_in;
  assign tx_valid_out = (state_r == ST_TX);
  assign tx_data_out = frame_r[175:168];
  assign tx_last_out = tx_valid_out && (tx_cnt_r == 5'h01);
  assign busy_out = (state_r != ST_IDLE);
  assign klen = amx_exp_len(elem_id);

  ////////////////////////////////////////////////////////////////////////////
  // octet walker over received messages
  amx_ie_parser amx_ie_parser_inst
  (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in),
    .rx_last_in(rx_last_in),
    .type_vld_out(type_vld),
    .id_vld_out(id_vld),
    .len_vld_out(len_vld),
    .body_vld_out(body_vld),
    .elem_last_out(elem_last),
    .elem_id_out(elem_id),
    .msg_end_out(msg_end),
    .msg_end_ok_out(msg_end_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive side: gather element contents and judge the message
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      mtype_r <= 8'h00;
      bad_r <= 1'b0;
      seen_r <= 4'h0;
      rand_acc_r <= 64'h0000000000000000;
      seed_acc_r <= 64'h0000000000000000;
      res_acc_r <= 32'h00000000;
      ktype_acc_r <= 24'h000000;
    end
    else
    begin
      // new message: forget what the last one held
      if (type_vld)
      begin
        mtype_r <= rx_data_in;
        seen_r <= 4'h0;
        bad_r <= rx_data_in[`AMX_MT_MSB];
      end
      // known element with a wrong length spoils the message
      if (len_vld && klen != 8'h00 && rx_data_in != klen)
        bad_r <= 1'b1;
      // content shifts in first octet on top, lsb ends in bit 0 of last
      if (body_vld)
        case (elem_id)
          `AMX_EI_RAND: rand_acc_r <= {rand_acc_r[55:0], rx_data_in};
          `AMX_EI_SEED: seed_acc_r <= {seed_acc_r[55:0], rx_data_in};
          `AMX_EI_RES: res_acc_r <= {res_acc_r[23:0], rx_data_in};
          `AMX_EI_KTYPE: ktype_acc_r <= {ktype_acc_r[15:0], rx_data_in};
          default: ; // other elements are passed over
        endcase
      // mark an element present once its content is complete
      if (elem_last)
        case (elem_id)
          `AMX_EI_KTYPE: seen_r[3] <= 1'b1;
          `AMX_EI_SEED: seen_r[2] <= 1'b1;
          `AMX_EI_RES: seen_r[1] <= 1'b1;
          `AMX_EI_RAND: seen_r[0] <= 1'b1;
          default: ;
        endcase
    end
  end

  // presence of each element including the octet now closing
  wire last_kt = elem_last && (elem_id == `AMX_EI_KTYPE);
  wire last_sd = elem_last && (elem_id == `AMX_EI_SEED);
  wire last_rs = elem_last && (elem_id == `AMX_EI_RES);
  wire last_rd = elem_last && (elem_id == `AMX_EI_RAND);
  wire has_kt = seen_r[3] || last_kt;
  wire has_sd = seen_r[2] || last_sd;
  wire has_rs = seen_r[1] || last_rs;
  wire has_rd = seen_r[0] || last_rd;
  // type octet of a one-octet message is judged on itself
  wire [7:0] cur_type = type_vld ? rx_data_in : mtype_r;
  wire cur_bad = type_vld ? rx_data_in[`AMX_MT_MSB] : bad_r;
  wire msg_good = msg_end_ok && !cur_bad;
  wire got_req = msg_good && (cur_type == `AMX_MT_REQ) && has_kt && has_sd && has_rd;
  wire got_reply = msg_good && (cur_type == `AMX_MT_REPLY) && has_sd && has_rs;
  // final values as complete words, also on the closing octet
  wire [63:0] rand_fin = last_rd ? {rand_acc_r[55:0], rx_data_in} : rand_acc_r;
  wire [63:0] seed_fin = last_sd ? {seed_acc_r[55:0], rx_data_in} : seed_acc_r;
  wire [31:0] res_fin = last_rs ? {res_acc_r[23:0], rx_data_in} : res_acc_r;
  wire [23:0] kt_fin = last_kt ? {ktype_acc_r[15:0], rx_data_in} : ktype_acc_r;
  ////////////////////////////////////////////////////////////////////////////
  // control: send frames, hand values out, compare responses
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      state_r <= ST_IDLE;
      tx_is_req_r <= 1'b0;
      frame_r <= {176{1'b0}};
      tx_cnt_r <= 5'h00;
      challenge_out <= 1'b0;
      rand_f_out <= 64'h0000000000000000;
      seed_element_out <= 64'h0000000000000000;
      key_type_out <= 24'h000000;
      reply_out <= 1'b0;
      fixed_response_out <= 32'h00000000;
      auth_pass_out <= 1'b0;
      drop_call_out <= 1'b0;
      msg_error_out <= 1'b0;
    end
    else
    begin
      challenge_out <= 1'b0;
      reply_out <= 1'b0;
      auth_pass_out <= 1'b0;
      drop_call_out <= 1'b0;
      // any message that ends broken or unexpected is reported
      msg_error_out <= msg_end && !(got_req && state_r == ST_IDLE) &&
        !(got_reply && state_r == ST_WREPLY);
      case (state_r)
        ST_IDLE:
          if (got_req)
          begin
            // fixed originated challenge: hand values to the response engine
            rand_f_out <= rand_fin;
            seed_element_out <= seed_fin;
            key_type_out <= kt_fin;
            challenge_out <= 1'b1;
            state_r <= ST_WRES;
          end
          else if (start_auth_in)
          begin
            // type, key type, challenge, optional response, msb first
            frame_r <= {`AMX_MT_REQ,
              `AMX_EI_KTYPE, `AMX_LEN_KTYPE - `AMX_LEN_OVH, key_type_in,
              `AMX_EI_RAND, `AMX_LEN_RAND - `AMX_LEN_OVH, rand_p_in,
              `AMX_EI_RES, `AMX_LEN_RES - `AMX_LEN_OVH, alloc_response_in};
            // response element only rides along for key allocation
            tx_cnt_r <= key_alloc_in ? `AMX_TX_REQ_RES_BYTES : `AMX_TX_REQ_BYTES;
            tx_is_req_r <= 1'b1;
            state_r <= ST_TX;
          end
        ST_WRES:
          if (resp_valid_in)
          begin
            // reply carrying the computed response
            frame_r <= {`AMX_MT_REPLY, `AMX_EI_RES,
              `AMX_LEN_RES - `AMX_LEN_OVH, portable_response_in, {120{1'b0}}};
            tx_cnt_r <= `AMX_TX_REPLY_BYTES;
            tx_is_req_r <= 1'b0;
            state_r <= ST_TX;
          end
        ST_TX:
          if (tx_fire)
          begin
            frame_r <= {frame_r[167:0], 8'h00};
            tx_cnt_r <= tx_cnt_r - 5'h01;
            if (tx_cnt_r == 5'h01)
              state_r <= tx_is_req_r ? ST_WREPLY : ST_IDLE;
          end
        ST_WREPLY:
          if (got_reply)
          begin
            // fixed answer: seed for the expected response computation
            seed_element_out <= seed_fin;
            fixed_response_out <= res_fin;
            reply_out <= 1'b1;
            state_r <= ST_WXRES;
          end
        ST_WXRES:
          if (xres_valid_in)
          begin
            // whole-word equality, one verdict
            auth_pass_out <= (expected_fixed_response_in == fixed_response_out);
            drop_call_out <= (expected_fixed_response_in != fixed_response_out);
            state_r <= ST_IDLE;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end
endmodule // amx_auth_pp

//--- verification/amx_auth_pp_monitor.sv
// Purpose: timing and framing checks on the portable side framer
// Assumes: sees only the framer's ports, one clock domain
// Notes: head_r and cnt_r follow the transmit stream frame by frame
`timescale 1ns/10ps

module amx_auth_pp_monitor
(
  // clock and reset
  input wire mclk_in,
  input wire resetn_in,
  // streams
  input wire rx_valid_in,
  input wire rx_last_in,
  input wire tx_valid_out,
  input wire [7:0] tx_data_out,
  input wire tx_last_out,
  input wire tx_ready_in,
  // control and results
  input wire start_auth_in,
  input wire challenge_out,
  input wire busy_out,
  input wire msg_error_out,
  input wire xres_valid_in,
  input wire [31:0] expected_fixed_response_in,
  input wire [31:0] fixed_response_out,
  input wire auth_pass_out,
  input wire drop_call_out
);
  logic head_r; // next accepted octet opens a frame
  logic [4:0] cnt_r; // octets accepted so far in this frame

  ////////////////////////////////////////////////////////////////////////////////
  // frame tracking
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      head_r <= 1'b1;
      cnt_r <= 5'h00;
    end
    else if (tx_valid_out && tx_ready_in)
    begin
      head_r <= tx_last_out;
      cnt_r <= tx_last_out ? 5'h00 : cnt_r + 5'h01;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  ////////////////////////////////////////////////////////////////////////////////
  // properties
  property p_type_code;
    tx_valid_out && head_r |-> tx_data_out inside {8'h20, 8'h41};
  endproperty
  property p_type_msb;
    tx_valid_out && head_r |-> !tx_data_out[7];
  endproperty
  property p_start;
    start_auth_in && !busy_out && !rx_valid_in |=> tx_valid_out && tx_data_out == 8'h20;
  endproperty
  property p_req_key;
    tx_valid_out && tx_ready_in && head_r && tx_data_out == 8'h20 |=> tx_data_out == 8'h0A;
  endproperty
  property p_reply_res;
    tx_valid_out && tx_ready_in && head_r && tx_data_out == 8'h41 |=> tx_data_out == 8'h0D;
  endproperty
  property p_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out);
  endproperty
  property p_frame_len;
    tx_valid_out && tx_last_out |-> cnt_r inside {5'h06, 5'h0F, 5'h15};
  endproperty
  property p_chal;
    challenge_out |-> busy_out && $past(rx_valid_in && rx_last_in);
  endproperty
  property p_err;
    msg_error_out |-> $past(rx_valid_in && rx_last_in);
  endproperty
  property p_verdict;
    auth_pass_out || drop_call_out |-> $past(xres_valid_in) && (auth_pass_out != drop_call_out)
      && (auth_pass_out == ($past(expected_fixed_response_in) == fixed_response_out));
  endproperty
  property p_idle;
    auth_pass_out || drop_call_out |-> !busy_out;
  endproperty

  a_type_code: assert property (p_type_code) else $error("bad type code");
  a_type_msb: assert property (p_type_msb) else $error("type top bit set");
  a_start: assert property (p_start) else $error("request not started");
  a_req_key: assert property (p_req_key) else $error("key type not first");
  a_reply_res: assert property (p_reply_res) else $error("reply lacks response");
  a_hold: assert property (p_hold) else $error("octet changed unaccepted");
  a_frame_len: assert property (p_frame_len) else $error("bad frame length");
  a_chal: assert property (p_chal) else $error("stray challenge pulse");
  a_err: assert property (p_err) else $error("stray error pulse");
  a_verdict: assert property (p_verdict) else $error("wrong verdict");
  a_idle: assert property (p_idle) else $error("busy after verdict");

  c_challenge: cover property (challenge_out);
  c_pass: cover property (auth_pass_out);
  c_drop: cover property (drop_call_out);
  c_error: cover property (msg_error_out);
endmodule // amx_auth_pp_monitor

bind amx_auth_pp amx_auth_pp_monitor amx_auth_pp_monitor_inst (.*);

//--- verification/amx_fp_model.sv
// Purpose: fixed side peer feeding and draining the portable framer
// Assumes: bench calls its tasks; one octet per clock on receive
// Notes: released receive data shows the inverse of the last octet
`timescale 1ns/10ps

module amx_fp_model
(
  // clock
  input wire mclk_in,
  // octets towards the portable side
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out,
  // octets from the portable side
  input wire tx_valid_in,
  input wire [7:0] tx_data_in,
  input wire tx_last_in,
  output logic tx_ready_out,
  // stall enable
  input wire slow_in
);
  logic [7:0] got[$]; // octets of received frames
  int frames = 0; // completed frames
  logic [7:0] stall_r = 8'hB5; // rotating stall pattern

  initial
  begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    rx_last_out = 1'b0;
    tx_ready_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sink with optional stalls
  always @(posedge mclk_in)
  begin
    if (tx_valid_in && tx_ready_out)
    begin
      got.push_back(tx_data_in);
      frames <= frames + (tx_last_in ? 1 : 0);
    end
    stall_r <= {stall_r[6:0], stall_r[7]};
    tx_ready_out <= !slow_in || stall_r[0];
  end

  // append n octets of v, most significant first
  task automatic put(ref logic [7:0] q[$], input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[8*i+:8]);
  endtask

  // drive one message, one octet per clock
  task automatic send(input logic [7:0] m[$]);
    for (int i = 0; i < m.size(); i++)
    begin
      @(posedge mclk_in);
      rx_valid_out <= 1'b1;
      rx_data_out <= m[i];
      rx_last_out <= (i == m.size() - 1);
    end
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_last_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
  endtask

  // challenge built from seed, challenge and key type in hand
  task automatic fixed_req(input logic [7:0] ty, input logic [23:0] k, input logic [63:0] s, r);
    logic [7:0] m[$];
    m.push_back(ty);
    put(m, {16'h0A03, k}, 5);
    put(m, 32'h7B02A55A, 4);
    put(m, 16'h0E08, 2);
    put(m, s, 8);
    put(m, 16'h0C08, 2);
    put(m, r, 8);
    send(m);
  endtask

  // reply with seed and fixed response
  task automatic fixed_reply(input logic [63:0] s, input logic [31:0] res);
    logic [7:0] m[$];
    m.push_back(8'h41);
    put(m, 16'h0E08, 2);
    put(m, s, 8);
    put(m, 16'h0D04, 2);
    put(m, res, 4);
    send(m);
  endtask

  // fixed side verdict on the last reply frame: high means drop
  function automatic logic judge(input logic [31:0] xres);
    return {got[$-3], got[$-2], got[$-1], got[$]} !== xres;
  endfunction
endmodule // amx_fp_model

//--- verification/amx_auth_pp_test.sv
// Purpose: self-checking bench of the portable side framer
// Assumes: fixed side peer model on the streams
// Notes: random values from an lfsr seeded with a fixed value
`timescale 1ns/10ps

module amx_auth_pp_test;
  logic mclk_in = 1'b0; // bench clock
  logic resetn_in = 1'b0; // active low reset
  wire rx_valid_in, rx_last_in, tx_valid_out, tx_last_out, tx_ready_in;
  wire [7:0] rx_data_in, tx_data_out;
  logic start_auth_in = 1'b0, key_alloc_in = 1'b0, resp_valid_in = 1'b0;
  logic xres_valid_in = 1'b0, slow = 1'b0, hit;
  logic [63:0] rand_p_in = 64'h0, r, s;
  logic [23:0] key_type_in = 24'h0, k;
  logic [31:0] alloc_response_in = 32'h0, portable_response_in = 32'h0, res, x;
  logic [31:0] expected_fixed_response_in = 32'h0, rs = 32'h22B3;
  wire challenge_out, reply_out, auth_pass_out, drop_call_out, msg_error_out, busy_out;
  wire [63:0] rand_f_out, seed_element_out;
  wire [23:0] key_type_out;
  wire [31:0] fixed_response_out;
  logic [7:0] e[$]; // expected frame
  int bad_count = 0, checks_done = 0, cycles = 0;

  amx_auth_pp amx_auth_pp_inst (.*);
  amx_fp_model amx_fp_model_inst (.mclk_in(mclk_in), .rx_valid_out(rx_valid_in),
    .rx_data_out(rx_data_in), .rx_last_out(rx_last_in), .tx_valid_in(tx_valid_out),
    .tx_data_in(tx_data_out), .tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in),
    .slow_in(slow));

  always #12.5 mclk_in = ~mclk_in;

  // hang guard
  always @(posedge mclk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction

  task stop_test;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string n, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // wait up to five clocks for a pulse: 0 challenge, 1 reply, 2 verdict, 3 error
  task poll(input int sel);
    hit = 1'b0;
    for (int i = 0; i < 5 && !hit; i++)
    begin
      // the pulse may already stand after the edge the caller returned on
      #1;
      hit = (sel == 0 ? challenge_out : sel == 1 ? reply_out :
        sel == 2 ? auth_pass_out | drop_call_out : msg_error_out) === 1'b1;
      if (!hit)
        @(posedge mclk_in);
    end
  endtask

  // collect one transmitted frame and compare it octet by octet
  task frame;
    int f;
    f = amx_fp_model_inst.frames;
    amx_fp_model_inst.got.delete();
    for (int i = 0; i < 300 && amx_fp_model_inst.frames == f; i++)
      @(posedge mclk_in);
    chk("frame size", amx_fp_model_inst.got.size(), e.size());
    foreach (e[i]) chk("frame octet", amx_fp_model_inst.got[i], e[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (12) @(posedge mclk_in);
    resetn_in <= 1'b1;
    // malformed type code, then a reply nobody asked for
    amx_fp_model_inst.fixed_req(8'hA0, 24'h000001, 64'h2, 64'h3);
    poll(3);
    chk("bad type flagged", hit, 1'b1);
    amx_fp_model_inst.fixed_reply(64'h5, 32'h6);
    poll(3);
    chk("stray reply flagged", hit, 1'b1);
    for (int n = 0; n < 6; n++)
    begin
      k = rnd();
      r = {rnd(), rnd()};
      s = {rnd(), rnd()};
      res = rnd();
      slow <= n[1] ^ n[0];
      // fixed originated challenge and the portable reply
      amx_fp_model_inst.fixed_req(8'h20, k, s, r);
      poll(0);
      chk("challenge", hit, 1'b1);
      chk("rand_f", rand_f_out, r);
      chk("seed", seed_element_out, s);
      chk("key type", key_type_out, k);
      @(posedge mclk_in);
      resp_valid_in <= 1'b1;
      portable_response_in <= res;
      @(posedge mclk_in);
      resp_valid_in <= 1'b0;
      e = {8'h41};
      amx_fp_model_inst.put(e, {16'h0D04, res}, 6);
      frame();
      chk("fixed verdict", amx_fp_model_inst.judge(res), 1'b0);
      // portable originated challenge, optionally with allocation response
      @(posedge mclk_in);
      start_auth_in <= 1'b1;
      rand_p_in <= r;
      key_type_in <= k;
      key_alloc_in <= n[1];
      alloc_response_in <= res;
      @(posedge mclk_in);
      start_auth_in <= 1'b0;
      e = {8'h20};
      amx_fp_model_inst.put(e, {16'h0A03, k}, 5);
      amx_fp_model_inst.put(e, 16'h0C08, 2);
      amx_fp_model_inst.put(e, r, 8);
      if (n[1])
        amx_fp_model_inst.put(e, {16'h0D04, res}, 6);
      frame();
      x = rnd();
      amx_fp_model_inst.fixed_reply(~s, x);
      poll(1);
      chk("reply", hit, 1'b1);
      chk("fixed response", fixed_response_out, x);
      chk("reply seed", seed_element_out, ~s);
      @(posedge mclk_in);
      xres_valid_in <= 1'b1;
      expected_fixed_response_in <= x ^ (n[0] ? 32'h1 << rs[4:0] : 32'h0);
      poll(2);
      chk("verdict", {auth_pass_out, drop_call_out}, n[0] ? 2'b01 : 2'b10);
      @(posedge mclk_in);
      xres_valid_in <= 1'b0;
      #1;
      chk("idle", busy_out, 1'b0);
    end
    stop_test();
  end
endmodule // amx_auth_pp_test
